// file: tit_defs.svh
`ifndef TIT_DEFS_SVH
`define TIT_DEFS_SVH

// ==========================================================
// Register offsets
`define TIT_OFF_CNT0  4'h0
`define TIT_OFF_CNT1  4'h4
`define TIT_OFF_CNT2  4'h8
`define TIT_OFF_CTRL  4'hC

// ==========================================================
// Control byte fields
`define TIT_SEL_HI    7
`define TIT_SEL_LO    6
`define TIT_ACC_HI    5
`define TIT_ACC_LO    4
`define TIT_MODE_HI   3
`define TIT_MODE_LO   1
`define TIT_BCD_BIT   0
`define TIT_SEL_BAD   2'h3

// ==========================================================
// Reset values and counts
`define TIT_STATE_RST '0
`define TIT_RDATA_RST 8'h00
`define TIT_NUM_CNT   3

`endif

// file: tit_pkg.sv
package tit_pkg;

  // ==========================================================
  // Modes, normalised so codes 6 and 7 never get stored
  typedef enum logic [2:0] {
    TIT_M0 = 3'b000,
    TIT_M1 = 3'b001,
    TIT_M2 = 3'b010,
    TIT_M3 = 3'b011,
    TIT_M4 = 3'b100,
    TIT_M5 = 3'b101
  } tit_mode_e;

  typedef enum logic [1:0] {
    TIT_LATCH = 2'b00,
    TIT_LSB   = 2'b01,
    TIT_MSB   = 2'b10,
    TIT_BOTH  = 2'b11
  } tit_acc_e;

  // ==========================================================
  // One counter channel
  typedef struct packed {
    tit_mode_e   mode;
    tit_acc_e    acc;
    logic        bcd;
    logic [15:0] cr;
    logic [15:0] ce;
    logic [15:0] ol;
    logic        latched;
    logic        wr_hi;
    logic        rd_hi;
    logic        pend;
    logic        run;
    logic        armed;
    logic        trig;
    logic        out;
    logic        gate_q;
    logic        clk_q;
  } tit_cnt_s;

  typedef struct packed {
    tit_cnt_s [2:0] cnt;
    logic [7:0]     rdata;
  } tit_top_s;

endpackage

// file: tit_bus_if.sv
`timescale 1ns/1ps
interface tit_bus_if;
  logic [2:0]         ctl_wr;
  logic [2:0]         ctl_latch;
  logic [2:0]         data_wr;
  logic [2:0]         data_rd;
  tit_pkg::tit_mode_e mode;
  tit_pkg::tit_acc_e  acc;
  logic               bcd;
  logic [7:0]         wdata;

  modport dec (
    output ctl_wr, ctl_latch, data_wr, data_rd, mode, acc, bcd, wdata
  );
  modport core (
    input ctl_wr, ctl_latch, data_wr, data_rd, mode, acc, bcd, wdata
  );
endinterface

// file: tit_decode.sv
`timescale 1ns/1ps
`include "tit_defs.svh"
module tit_decode (
  input  wire logic [3:0] i_addr,
  input  wire logic       i_wr,
  input  wire logic       i_rd,
  input  wire logic [7:0] i_wdata,
  tit_bus_if.dec          bus
);

  // ==========================================================
  // Address decode, shared by the read and write strobes
  function automatic logic [2:0] tit_hit(input logic [3:0] a);
    unique case (a)
      `TIT_OFF_CNT0: tit_hit = 3'h1;
      `TIT_OFF_CNT1: tit_hit = 3'h2;
      `TIT_OFF_CNT2: tit_hit = 3'h4;
      default:       tit_hit = 3'h0;
    endcase
  endfunction

  logic [1:0] sel;
  logic [2:0] sel_hot;
  logic       ctl_hit;

  assign sel     = i_wdata[`TIT_SEL_HI:`TIT_SEL_LO];
  assign ctl_hit = i_wr && (i_addr == `TIT_OFF_CTRL) && (sel != `TIT_SEL_BAD);
  assign sel_hot = ctl_hit ? (3'h1 << sel) : 3'h0;

  assign bus.acc   = tit_pkg::tit_acc_e'(i_wdata[`TIT_ACC_HI:`TIT_ACC_LO]);
  assign bus.bcd   = i_wdata[`TIT_BCD_BIT];
  assign bus.wdata = i_wdata;
  // Bit 3 is a don't-care once bit 2 is set
  assign bus.mode  = i_wdata[2] ?
                     tit_pkg::tit_mode_e'({1'b0, i_wdata[2:1]}) :
                     tit_pkg::tit_mode_e'(i_wdata[`TIT_MODE_HI:`TIT_MODE_LO]);
  assign bus.ctl_latch = (bus.acc == tit_pkg::TIT_LATCH) ? sel_hot : 3'h0;
  assign bus.ctl_wr    = (bus.acc != tit_pkg::TIT_LATCH) ? sel_hot : 3'h0;
  assign bus.data_wr   = i_wr ? tit_hit(i_addr) : 3'h0;
  assign bus.data_rd   = i_rd ? tit_hit(i_addr) : 3'h0;

endmodule

// file: tit_top.sv
`timescale 1ns/1ps
`include "tit_defs.svh"
module tit_top (
  input  wire logic       i_clk,
  input  wire logic       i_rst,
  input  wire logic [3:0] i_addr,
  input  wire logic       i_wr,
  input  wire logic       i_rd,
  input  wire logic [7:0] i_wdata,
  output logic      [7:0] o_rdata,
  input  wire logic [2:0] i_cnt_clk,
  input  wire logic [2:0] i_gate,
  output logic      [2:0] o_out
);

  // ==========================================================
  // Decrement helpers
  function automatic logic [15:0] tit_dec1(
    input logic [15:0] v,
    input logic        bcd
  );
    logic [15:0] r;
    logic        borrow;
    r      = v;
    borrow = 1'b1;
    if (bcd)
    begin
      for (int d = 0; d < 4; d++)
      begin
        if (borrow)
        begin
          if (r[d*4 +: 4] == 4'h0)
          begin
            r[d*4 +: 4] = 4'h9;
          end
          else
          begin
            r[d*4 +: 4] = r[d*4 +: 4] - 4'h1;
            borrow      = 1'b0;
          end
        end
      end
    end
    else
    begin
      r = v - 16'h0001;
    end
    return r;
  endfunction

  function automatic logic [15:0] tit_dec(
    input logic [15:0] v,
    input logic        bcd,
    input logic [1:0]  amt
  );
    logic [15:0] r;
    r = v;
    for (int k = 0; k < 3; k++)
    begin
      if (k < int'(amt))
      begin
        r = tit_dec1(r, bcd);
      end
    end
    return r;
  endfunction

  // ==========================================================
  // Decoded register bus
  tit_bus_if bus ();

  tit_decode u_decode (
    .i_addr  (i_addr),
    .i_wr    (i_wr),
    .i_rd    (i_rd),
    .i_wdata (i_wdata),
    .bus     (bus.dec)
  );

  // ==========================================================
  // State
  tit_pkg::tit_top_s state_reg;
  tit_pkg::tit_top_s state_next;

  always_comb
  begin
    tit_pkg::tit_cnt_s c;
    logic              tick;
    logic              gate;
    logic              hi;
    logic [15:0]       src;
    logic [1:0]        amt;
    c          = '0;
    tick       = 1'b0;
    gate       = 1'b0;
    hi         = 1'b0;
    src        = 16'h0000;
    amt        = 2'h0;
    state_next = state_reg;
    // Each channel is fully independent of the others
    for (int i = 0; i < `TIT_NUM_CNT; i++)
    begin
      c       = state_reg.cnt[i];
      gate    = i_gate[i];
      // Count clock acts on its falling edge
      tick    = c.clk_q && !i_cnt_clk[i];
      c.clk_q = i_cnt_clk[i];
      if (gate && !c.gate_q)
      begin
        c.trig = 1'b1;
      end
      c.gate_q = gate;

      // ========================================================
      // Control byte
      if (bus.ctl_wr[i])
      begin
        c.mode    = bus.mode;
        c.acc     = bus.acc;
        c.bcd     = bus.bcd;
        c.wr_hi   = 1'b0;
        c.rd_hi   = 1'b0;
        c.pend    = 1'b0;
        c.run     = 1'b0;
        c.armed   = 1'b0;
        c.trig    = gate && !state_reg.cnt[i].gate_q;
        c.latched = 1'b0;
        c.out     = (bus.mode != tit_pkg::TIT_M0);
      end
      if (bus.ctl_latch[i] && !c.latched)
      begin
        c.ol      = c.ce;
        c.latched = 1'b1;
      end

      // ========================================================
      // Count write
      if (bus.data_wr[i])
      begin
        unique case (c.acc)
          tit_pkg::TIT_LSB:
          begin
            c.cr   = {8'h00, bus.wdata};
            c.pend = 1'b1;
          end
          tit_pkg::TIT_MSB:
          begin
            c.cr   = {bus.wdata, 8'h00};
            c.pend = 1'b1;
          end
          tit_pkg::TIT_BOTH:
          begin
            if (!c.wr_hi)
            begin
              c.cr[7:0] = bus.wdata;
              c.wr_hi   = 1'b1;
              if (c.mode == tit_pkg::TIT_M0)
              begin
                c.run = 1'b0;
              end
            end
            else
            begin
              c.cr[15:8] = bus.wdata;
              c.wr_hi    = 1'b0;
              c.pend     = 1'b1;
            end
          end
          default:
          begin
            c.pend = c.pend;
          end
        endcase
        if (c.pend && !c.wr_hi)
        begin
          c.armed = 1'b1;
          if (c.mode == tit_pkg::TIT_M0)
          begin
            c.out = 1'b0;
          end
        end
      end

      // ========================================================
      // Count read; never disturbs counting
      if (bus.data_rd[i])
      begin
        src = c.latched ? c.ol : c.ce;
        hi  = (c.acc == tit_pkg::TIT_MSB) ||
              ((c.acc == tit_pkg::TIT_BOTH) && c.rd_hi);
        state_next.rdata = hi ? src[15:8] : src[7:0];
        if ((c.acc != tit_pkg::TIT_BOTH) || c.rd_hi)
        begin
          c.latched = 1'b0;
        end
        if (c.acc == tit_pkg::TIT_BOTH)
        begin
          c.rd_hi = !c.rd_hi;
        end
      end

      // ========================================================
      // Counting on each count clock
      if (tick)
      begin
        unique case (c.mode)
          tit_pkg::TIT_M0:
          begin
            if (c.pend && !c.wr_hi)
            begin
              c.ce   = c.cr;
              c.pend = 1'b0;
              c.run  = 1'b1;
            end
            else if (c.run && gate)
            begin
              // Keeps wrapping after terminal count
              c.ce = tit_dec1(c.ce, c.bcd);
              if (c.ce == 16'h0000)
              begin
                c.out = 1'b1;
              end
            end
          end
          tit_pkg::TIT_M1:
          begin
            // A count written mid-pulse waits for the next trigger
            if (c.trig && c.armed)
            begin
              c.ce  = c.cr;
              c.out = 1'b0;
              c.run = 1'b1;
            end
            else if (c.run)
            begin
              c.ce = tit_dec1(c.ce, c.bcd);
              if (c.ce == 16'h0000)
              begin
                c.out = 1'b1;
              end
            end
          end
          tit_pkg::TIT_M2:
          begin
            if (gate && c.armed && (c.trig || (c.pend && !c.run)))
            begin
              c.ce   = c.cr;
              c.run  = 1'b1;
              c.pend = 1'b0;
              c.out  = 1'b1;
            end
            else if (c.run && gate)
            begin
              if (c.ce == 16'h0002)
              begin
                c.out = 1'b0;
                c.ce  = 16'h0001;
              end
              else if (c.ce == 16'h0001)
              begin
                // New count takes effect at the period boundary or on a gate trigger
                c.out  = 1'b1;
                c.ce   = c.cr;
                c.pend = 1'b0;
              end
              else
              begin
                c.ce = tit_dec1(c.ce, c.bcd);
              end
            end
          end
          tit_pkg::TIT_M3:
          begin
            if (gate && c.armed && (c.trig || (c.pend && !c.run)))
            begin
              c.ce   = c.cr;
              c.run  = 1'b1;
              c.pend = 1'b0;
              c.out  = 1'b1;
            end
            else if (c.run && gate)
            begin
              // Odd count: first step is 1 when high, 3 when low
              amt = c.ce[0] ? (c.out ? 2'h1 : 2'h3) : 2'h2;
              if (c.ce <= {14'h0000, amt})
              begin
                c.out  = !c.out;
                c.ce   = c.cr;
                c.pend = 1'b0;
              end
              else
              begin
                c.ce = tit_dec(c.ce, c.bcd, amt);
              end
            end
          end
          tit_pkg::TIT_M4:
          begin
            if (c.pend)
            begin
              c.ce   = c.cr;
              c.pend = 1'b0;
              c.run  = 1'b1;
              c.out  = 1'b1;
            end
            else if (c.run && gate)
            begin
              if (!c.out)
              begin
                c.out = 1'b1;
                c.run = 1'b0;
              end
              else
              begin
                c.ce = tit_dec1(c.ce, c.bcd);
                if (c.ce == 16'h0000)
                begin
                  c.out = 1'b0;
                end
              end
            end
          end
          tit_pkg::TIT_M5:
          begin
            if (c.trig && c.armed)
            begin
              c.ce  = c.cr;
              c.run = 1'b1;
              c.out = 1'b1;
            end
            else if (c.run)
            begin
              if (!c.out)
              begin
                c.out = 1'b1;
                c.run = 1'b0;
              end
              else
              begin
                c.ce = tit_dec1(c.ce, c.bcd);
                if (c.ce == 16'h0000)
                begin
                  c.out = 1'b0;
                end
              end
            end
          end
          default:
          begin
            c.run = 1'b0;
          end
        endcase
        // A gate edge is consumed by the next count clock
        c.trig = 1'b0;
      end

      // ========================================================
      // Gate low holds modes 2 and 3 high
      if (!gate && ((c.mode == tit_pkg::TIT_M2) || (c.mode == tit_pkg::TIT_M3)))
      begin
        c.out = 1'b1;
      end

      state_next.cnt[i] = c;
    end
  end

  always_ff @(posedge i_clk)
  begin
    if (i_rst)
    begin
      state_reg <= `TIT_STATE_RST;
    end
    else
    begin
      state_reg <= state_next;
    end
  end

  // ==========================================================
  // Outputs
  assign o_rdata = state_reg.rdata;

  generate
    for (genvar g = 0; g < `TIT_NUM_CNT; g++)
    begin : g_out
      assign o_out[g] = state_reg.cnt[g].out;
    end
  endgenerate

endmodule

// file: tit_host.sv
`timescale 1ns/1ps
module tit_host (
  input  wire logic       i_clk,
  input  wire logic [7:0] i_junk,
  output logic      [3:0] o_addr,
  output logic            o_wr,
  output logic            o_rd,
  output logic      [7:0] o_wdata
);
  // ==========================================================
  // Byte cycles
  // Idle bus carries junk so a stale byte cannot pass for a real one
  initial
  begin
    o_addr  = 4'hF;
    o_wr    = 1'b0;
    o_rd    = 1'b0;
    o_wdata = 8'h00;
  end

  task automatic acc(input logic [3:0] a, input logic [7:0] d, input logic w);
    @(negedge i_clk);
    o_addr  = a;
    o_wdata = d;
    o_wr    = w;
    o_rd    = ~w;
    @(negedge i_clk);
    o_wr    = 1'b0;
    o_rd    = 1'b0;
    o_addr  = 4'hF;
    o_wdata = i_junk;
  endtask
endmodule

// file: tit_checker_properties.sv
`timescale 1ns/1ps
module tit_checker (
  input wire logic       i_clk,
  input wire logic       i_rst,
  input wire logic [3:0] i_addr,
  input wire logic       i_wr,
  input wire logic       i_rd,
  input wire logic [7:0] i_wdata,
  input wire logic [7:0] o_rdata,
  input wire logic [2:0] i_cnt_clk,
  input wire logic [2:0] i_gate,
  input wire logic [2:0] o_out
);
  // ==========================================================
  // Shadow of programmed modes and tick history
  logic [2:0] mode_reg [3];
  logic [1:0] low_tk_reg [3];
  logic [2:0] clk_reg;
  logic [2:0] gate_reg;
  logic [2:0] tick;
  logic [2:0] ev;
  logic       ctl_wr;

  assign ctl_wr = i_wr && i_addr == 4'hC && i_wdata[7:6] != 2'h3 && i_wdata[5:4] != 2'h0;
  assign tick   = clk_reg & ~i_cnt_clk;
  assign ev     = tick | (gate_reg ^ i_gate) | {3{i_wr}};

  always_ff @(posedge i_clk)
  begin
    clk_reg  <= i_cnt_clk;
    gate_reg <= i_gate;
    for (int k = 0; k < 3; k++)
    begin
      if (i_rst)
        mode_reg[k] <= 3'h0;
      else if (ctl_wr && i_wdata[7:6] == k)
        mode_reg[k] <= i_wdata[2] ? {1'b0, i_wdata[2:1]} : i_wdata[3:1];
      // Long low stretches of mode 0 must not leak into a later strobe mode
      if (i_rst || o_out[k] || ctl_wr)
        low_tk_reg[k] <= 2'h0;
      else if (tick[k] && low_tk_reg[k] != 2'h3)
        low_tk_reg[k] <= low_tk_reg[k] + 2'h1;
    end
  end

  // ==========================================================
  // Properties
  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (i_rst);

  AST_RST_QUIET: assert property (disable iff (1'b0)
    i_rst |=> o_out == 3'h0 && o_rdata == 8'h00) else $error("outputs not cleared by reset");
  AST_OUT_CAUSE: assert property (
    $changed(o_out[1]) |-> $past(ev[1]) || $past(ev[1], 2) || $past(i_rst))
    else $error("counter 1 output moved without a cause");
  AST_RDATA_HOLD: assert property (
    !($past(i_rd) && ($past(i_addr) inside {4'h0, 4'h4, 4'h8})) |-> $stable(o_rdata))
    else $error("read data moved without a counter read");
  AST_M0_PROG_LOW: assert property (
    ctl_wr && i_wdata[7:6] == 2'h0 && i_wdata[3:1] == 3'h0 |-> ##[1:2] !o_out[0])
    else $error("mode 0 output not low after programming");
  AST_M0_HOLD: assert property (
    mode_reg[0] == 3'h0 && o_out[0] && !i_wr && !$past(i_wr) && !$past(i_wr, 2) |=> o_out[0])
    else $error("mode 0 output fell without a write");
  AST_M2_ONE_LOW: assert property (
    mode_reg[0] == 3'h2 |-> low_tk_reg[0] < 2'h2) else $error("mode 2 pulse too long");
  AST_M2_GATE: assert property (
    (mode_reg[0] == 3'h2 && !i_gate[0])[*2] |=> o_out[0])
    else $error("mode 2 output low with gate low");
  AST_PROG_HIGH: assert property (
    ctl_wr && i_wdata[7:6] == 2'h2 && (i_wdata[2:1] == 2'h2 || i_wdata[3:1] == 3'h4)
    |-> ##[1:2] o_out[2]) else $error("output not high after programming");
  AST_M4_ONE_LOW: assert property (
    mode_reg[2] == 3'h4 |-> low_tk_reg[2] < 2'h2) else $error("mode 4 strobe too long");
  AST_M4_GATE: assert property (
    (!i_gate[2])[*2] ##0 (mode_reg[2] == 3'h4 && o_out[2] && !i_wr) |=> o_out[2])
    else $error("mode 4 strobe while gate low");

  COV_M5_SET: cover property (ctl_wr && i_wdata[3:1] == 3'h5);
  COV_M4_STROBE: cover property ($fell(o_out[2]) && mode_reg[2] == 3'h4);
  COV_RD_CNT1: cover property (i_rd && i_addr == 4'h4);
endmodule

bind tit_top tit_checker i_chk (
  .i_clk(i_clk), .i_rst(i_rst), .i_addr(i_addr), .i_wr(i_wr), .i_rd(i_rd),
  .i_wdata(i_wdata), .o_rdata(o_rdata), .i_cnt_clk(i_cnt_clk), .i_gate(i_gate),
  .o_out(o_out)
);

// file: triple_interval_timer_tb.sv
`timescale 1ns/1ps
module triple_interval_timer_tb;
  // ==========================================================
  // Signals
  logic       i_clk;
  logic       i_rst;
  logic [3:0] i_addr;
  logic       i_wr;
  logic       i_rd;
  logic [7:0] i_wdata;
  logic [7:0] o_rdata;
  wire  [2:0] i_cnt_clk;
  logic [2:0] i_gate;
  logic [2:0] o_out;
  logic [7:0] lfsr      = 8'h38;
  logic [3:0] div       = 4'h0;
  logic       snap;
  logic [1:0] snap_ch;
  logic       rd_q      = 1'b0;
  logic [7:0] rd_exp[$];
  logic       out_exp[$];
  int         n_fail    = 0;
  int         cmp_count = 0;

  // Count clock is 16 system clocks so bus work fits between ticks
  assign i_cnt_clk = {3{div[3]}};

  tit_top i_dut (
    .i_clk(i_clk), .i_rst(i_rst), .i_addr(i_addr), .i_wr(i_wr), .i_rd(i_rd),
    .i_wdata(i_wdata), .o_rdata(o_rdata), .i_cnt_clk(i_cnt_clk), .i_gate(i_gate),
    .o_out(o_out)
  );
  tit_host u_host (
    .i_clk(i_clk), .i_junk(lfsr), .o_addr(i_addr), .o_wr(i_wr), .o_rd(i_rd),
    .o_wdata(i_wdata)
  );

  function automatic logic [7:0] lfsr_next(input logic [7:0] v);
    return {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
  endfunction

  initial
  begin
    i_clk = 1'b0;
    forever #50 i_clk = ~i_clk;
  end

  always @(negedge i_clk)
  begin
    div  <= div + 4'h1;
    lfsr <= lfsr_next(lfsr);
  end

  // ==========================================================
  // Checking
  task automatic chk(input logic [7:0] e, input logic [7:0] g);
    cmp_count++;
    if (g !== e)
    begin
      n_fail++;
      $display("CHECK FAILED t=%0t exp=%h got=%h", $time, e, g);
    end
  endtask

  always @(posedge i_clk)
  begin
    if (rd_q === 1'b1)
      chk(rd_exp.pop_front(), o_rdata);
    if (snap === 1'b1)
      chk({7'h00, out_exp.pop_front()}, {7'h00, o_out[snap_ch]});
    rd_q <= i_rd;
  end

  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    u_host.acc(a, d, 1'b1);
  endtask

  task automatic rd(input logic [3:0] a, input logic [7:0] e);
    rd_exp.push_back(e);
    u_host.acc(a, 8'h00, 1'b0);
  endtask

  task automatic look(input logic [1:0] ch, input logic e);
    repeat (2) @(negedge i_clk);
    out_exp.push_back(e);
    snap_ch = ch;
    snap    = 1'b1;
    @(negedge i_clk);
    snap    = 1'b0;
  endtask

  task automatic ticks(input int n);
    repeat (n) @(negedge i_cnt_clk[0]);
  endtask

  task automatic pat(input logic [1:0] ch, input logic [9:0] p, input int n);
    for (int i = n - 1; i >= 0; i--)
    begin
      ticks(1);
      look(ch, p[i]);
    end
  endtask

  task automatic wrap_up();
    if (n_fail == 0 && cmp_count > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  initial
  begin
    repeat (5000) @(posedge i_clk);
    n_fail++;
    wrap_up();
  end

  // ==========================================================
  // Scenarios
  initial
  begin
    i_rst     = 1'b1;
    i_gate    = 3'h7;
    snap      = 1'b0;
    snap_ch   = 2'h0;
    repeat (6) @(negedge i_clk);
    i_rst = 1'b0;
    look(2'h0, 1'b0);
    rd(4'hC, 8'h00);
    // Mode 2 through code 110, divide by 3, then gate hold and restart
    // Writes must land between ticks, else the load tick goes unseen
    ticks(1);
    wr(4'hC, 8'h3C);
    wr(4'h0, 8'h03);
    wr(4'h0, 8'h00);
    pat(2'h0, 10'h036, 6);
    i_gate[0] = 1'b0;
    pat(2'h0, 10'h007, 3);
    i_gate[0] = 1'b1;
    pat(2'h0, 10'h006, 3);
    // Mode 0 decimal, 10 ticks, stays high
    wr(4'hC, 8'h31);
    wr(4'h0, 8'h10);
    wr(4'h0, 8'h00);
    look(2'h0, 1'b0);
    ticks(9);
    pat(2'h0, 10'h001, 2);
    pat(2'h0, 10'h003, 2);
    // Mode 0 rewrite halts on first byte
    wr(4'hC, 8'h30);
    wr(4'h0, 8'h04);
    wr(4'h0, 8'h00);
    pat(2'h0, 10'h000, 3);
    wr(4'h0, 8'h03);
    pat(2'h0, 10'h000, 4);
    wr(4'h0, 8'h00);
    pat(2'h0, 10'h001, 4);
    // Mode 3 through code 111, low byte only, odd count 5
    wr(4'hC, 8'h5E);
    wr(4'h4, 8'h05);
    i_gate[1] = 1'b0;
    @(negedge i_clk);
    i_gate[1] = 1'b1;
    pat(2'h1, 10'h39C, 10);
    // Mode 1 retrigger with a latched read in mid pulse
    i_gate[1] = 1'b0;
    wr(4'hC, 8'h72);
    wr(4'h4, 8'h03);
    wr(4'h4, 8'h00);
    i_gate[1] = 1'b1;
    pat(2'h1, 10'h000, 2);
    i_gate[1] = 1'b0;
    @(negedge i_clk);
    i_gate[1] = 1'b1;
    wr(4'hC, 8'h40);
    rd(4'h4, 8'h02);
    rd(4'h4, 8'h00);
    pat(2'h1, 10'h001, 4);
    // Mode 4 high byte only, gate low, illegal select, latch
    // A misrouted illegal byte would drop the pending count of counter 2
    i_gate[2] = 1'b0;
    wr(4'hC, 8'hA8);
    look(2'h2, 1'b1);
    wr(4'h8, 8'h12);
    wr(4'hC, 8'hE0);
    ticks(3);
    wr(4'hC, 8'h80);
    rd(4'h8, 8'h12);
    rd(4'h8, 8'h12);
    // Mode 4 strobe
    wr(4'hC, 8'hB8);
    i_gate[2] = 1'b1;
    wr(4'h8, 8'h02);
    wr(4'h8, 8'h00);
    pat(2'h2, 10'h01B, 5);
    // Mode 5 strobe after gate rise
    i_gate[0] = 1'b0;
    wr(4'hC, 8'h3A);
    wr(4'h0, 8'h02);
    wr(4'h0, 8'h00);
    i_gate[0] = 1'b1;
    pat(2'h0, 10'h00D, 4);
    repeat (4) @(negedge i_clk);
    wrap_up();
  end
endmodule
